// ==== rtl/ctx_regs_pkg.sv ====
package ctx_regs_pkg;

	// ==========================================================
	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;

	// ==========================================================
	// Register offsets
	localparam logic [11:0] OFS_FAULT_STATUS = 12'h000;
	localparam logic [11:0] OFS_FS_RESTORE = 12'h004;
	localparam logic [11:0] OFS_STALL_RESUME = 12'h008;
	localparam logic [11:0] OFS_SYNDROME_0 = 12'h00C;
	localparam logic [11:0] OFS_SYNDROME_1 = 12'h010;
	localparam logic [11:0] OFS_ATTR_0 = 12'h014;
	localparam logic [11:0] OFS_ATTR_1 = 12'h018;
	localparam logic [11:0] OFS_NORMAL_REMAP = 12'h01C;

	// ==========================================================
	// Fault status fields
	localparam int FS_MULTI_POS = 31;
	localparam int FS_STALL_POS = 30;
	localparam int FS_FMT_LO = 9;
	localparam int FS_FAULT_LO = 1;
	localparam logic [31:0] FS_STORE_MASK = 32'h8000_01FE;
	localparam logic [31:0] RST_FAULT_STATUS = 32'h0000_0000;
	localparam logic RST_STALL = 1'b0;

	// ==========================================================
	// Syndrome 0 fields
	localparam int SYN_IDX_LO = 16;
	localparam int SYN_ASYNC_POS = 11;
	localparam int SYN_WALKF_POS = 10;
	localparam int SYN_NS_POS = 8;
	localparam int SYN_INSTR_POS = 6;
	localparam int SYN_PRIV_POS = 5;
	localparam int SYN_DIR_POS = 4;
	localparam int SYN_LVL_LO = 0;
	localparam logic [31:0] SYN0_MASK = 32'h00FF_0D73;
	localparam logic [31:0] SYN0_IDX_MASK = 32'h00FF_0000;
	localparam logic [31:0] SYN0_NS_MASK = 32'h0000_0100;
	localparam logic [31:0] RST_SYNDROME = 32'h0000_0000;
	localparam logic [31:0] RST_ATTR = 32'h0000_0000;
	localparam logic [31:0] RST_REMAP = 32'h0000_0000;

	// ==========================================================
	// Remap fields and encodings
	localparam int REMAP_OUTER_LO = 16;
	localparam int MAP_W = 2;
	localparam int ATTR_W = 8;
	localparam logic [1:0] SCHEME_SHORT = 2'b00;
	localparam logic [1:0] SCHEME_LONG = 2'b01;
	localparam logic [1:0] SCHEME_WIDE = 2'b10;
	localparam logic [1:0] CACHE_NONE = 2'b00;
	localparam logic [1:0] CACHE_WB_WA = 2'b01;
	localparam logic [1:0] CACHE_WT_NA = 2'b10;
	localparam logic [1:0] CACHE_WB_NA = 2'b11;
	localparam logic [1:0] LEVEL_0 = 2'b00;
	localparam logic [1:0] LEVEL_1 = 2'b01;

	typedef enum logic [1:0]
	{
		FAULT_WALK = 2'b00,
		FAULT_TRANS = 2'b01,
		FAULT_ACCESS = 2'b10,
		FAULT_PERM = 2'b11
	} fault_class_t;

endpackage

// ==== rtl/context_fault_syndrome_attr_regs.sv ====
`timescale 1ns/100ps
// Contract
// - Restore write overwrites fault status, except stall flag and scheme field.
// - Stall flag clears only through a stall resume write.
// - Syndrome bits 23:16 hold first-stage bank index for nested translation.
// - Bank index field reads zero and ignores writes without nested support.
// - Syndrome bit 11 is 0 for synchronous, 1 for asynchronous recording.
// - Syndrome bit 10 set only for external fault during a table walk.
// - Secure bank: bit 8 is security after override; reserved elsewhere.
// - Syndrome bit 6 records instruction fetch after override.
// - Syndrome bit 5 records privileged access after override.
// - Syndrome bit 4 records write (1) versus read (0).
// - Failed far atomic reports the missing permission; otherwise read.
// - Syndrome bits 1:0 encode table level 0 to 3 ascending.
// - Walk faults report walked level; translation/access the faulting table.
// - Disabled walk or out-of-range address: level 0 wide, level 1 otherwise.
// - Permission faults report the final table level used.
// - Each attribute register holds four byte slots, lowest in bits 7:0.
// - Indirection used for long/wide schemes; remap registers for short scheme.
// - Bits 31:16 of remap hold eight outer maps indexed by type/C/B.
// - Map code 00 none, 01 WB-WA, 10 WT-NA, 11 WB-NA.
// - Bits 15:0 of remap hold eight inner maps, same index and code.
// - Inner map index 6 may carry an implementation meaning.
// - Stall flag reads 1 while stalled and resets to 0.
module context_fault_syndrome_attr_regs
(
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ctx_regs_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [ctx_regs_pkg::DATA_W-1:0] pwdata_in,
	input wire logic [ctx_regs_pkg::STRB_W-1:0] pstrb_in,
	output logic pready_out,
	output logic [ctx_regs_pkg::DATA_W-1:0] prdata_out,
	output logic pslverr_out,
	input wire logic [1:0] scheme_in,
	input wire logic nested_support_flag_in,
	input wire logic stage2_format_in,
	input wire logic secure_bank_in,
	input wire logic fault_record_in,
	input wire logic [7:0] fault_bits_in,
	input wire logic fault_stall_in,
	input wire logic fault_async_in,
	input wire logic fault_external_in,
	input wire ctx_regs_pkg::fault_class_t fault_class_in,
	input wire logic fault_no_walk_in,
	input wire logic [1:0] walk_level_in,
	input wire logic [1:0] table_level_in,
	input wire logic [1:0] final_level_in,
	input wire logic [7:0] first_stage_bank_index_in,
	input wire logic nonsecure_attr_in,
	input wire logic instr_not_data_in,
	input wire logic priv_not_unpriv_in,
	input wire logic write_not_read_in,
	input wire logic atomic_in,
	input wire logic atomic_no_read_in,
	input wire logic atomic_no_write_in,
	input wire logic [2:0] attr_index_in,
	input wire logic region_normal_in,
	output logic use_indirection_out,
	output logic [ctx_regs_pkg::ATTR_W-1:0] attr_out,
	output logic [1:0] outer_cache_map_out,
	output logic [1:0] inner_cache_map_out,
	output logic stalled_out
);
	import ctx_regs_pkg::*;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return res;
	endfunction

	function automatic logic [1:0] pick_map(input logic [15:0] maps, input logic [2:0] idx);
		return maps[idx*MAP_W +: MAP_W];
	endfunction

	// ==========================================================
	// State
	logic [31:0] fs_bits;
	logic stall;
	logic [31:0] syndrome_0;
	logic [31:0] syndrome_1;
	logic [31:0] attr_0;
	logic [31:0] attr_1;
	logic [31:0] normal_remap;

	// ==========================================================
	// Bus decode
	wire setup_phase = psel_in & ~penable_in;
	wire access_phase = psel_in & penable_in;
	wire wr_en = access_phase & pwrite_in;
	wire hit_fs = (paddr_in == OFS_FAULT_STATUS);
	wire hit_restore = (paddr_in == OFS_FS_RESTORE);
	wire hit_resume = (paddr_in == OFS_STALL_RESUME);
	wire hit_syn0 = (paddr_in == OFS_SYNDROME_0);
	wire hit_syn1 = (paddr_in == OFS_SYNDROME_1);
	wire hit_attr0 = (paddr_in == OFS_ATTR_0);
	wire hit_attr1 = (paddr_in == OFS_ATTR_1);
	wire hit_remap = (paddr_in == OFS_NORMAL_REMAP);
	wire mapped = hit_fs | hit_restore | hit_resume | hit_syn0 | hit_syn1 | hit_attr0
		| hit_attr1 | hit_remap;
	wire wr_ok = wr_en & mapped;
	wire [31:0] strb_mask = {{8{pstrb_in[3]}}, {8{pstrb_in[2]}}, {8{pstrb_in[1]}},
		{8{pstrb_in[0]}}};

	assign pready_out = 1'b1;

	// ==========================================================
	// Fault status
	wire [31:0] fs_read = fs_bits | ({31'h0000_0000, stall} << FS_STALL_POS)
		| ({30'h0000_0000, scheme_in} << FS_FMT_LO);
	wire rec_multi = fault_record_in & (|fs_bits[8:1]);
	wire [31:0] fs_set = fault_record_in ? (({24'h00_0000, fault_bits_in} << FS_FAULT_LO)
		| ({31'h0000_0000, rec_multi} << FS_MULTI_POS)) : 32'h0000_0000;
	wire [31:0] fs_w1c = (wr_ok & hit_fs) ? (pwdata_in & strb_mask & FS_STORE_MASK)
		: 32'h0000_0000;
	// Restore masks out stall and scheme; the scheme is never stored here anyway
	wire [31:0] fs_restored = merge_strb(fs_bits, pwdata_in, pstrb_in) & FS_STORE_MASK;
	wire [31:0] fs_base = (wr_ok & hit_restore) ? fs_restored : (fs_bits & ~fs_w1c);
	// New fault wins over a clear in the same cycle
	wire [31:0] next_fs_bits = (fs_base | fs_set) & FS_STORE_MASK;
	wire resume_wr = wr_ok & hit_resume;
	wire next_stall = (fault_record_in & fault_stall_in) ? 1'b1 : (resume_wr ? 1'b0 : stall);

	always_ff @(posedge core_clk_in)
	begin
		if (!rstn_in)
		begin
			fs_bits <= RST_FAULT_STATUS;
			stall <= RST_STALL;
		end
		else
		begin
			fs_bits <= next_fs_bits;
			stall <= next_stall;
		end
	end

	assign stalled_out = stall;

	// ==========================================================
	// Syndrome capture
	wire index_ok = nested_support_flag_in & stage2_format_in;
	// Unknown fields read as zero; cheaper than keeping stale state visible
	wire [31:0] syn0_rmask = SYN0_MASK & ~(index_ok ? 32'h0000_0000 : SYN0_IDX_MASK)
		& ~(secure_bank_in ? 32'h0000_0000 : SYN0_NS_MASK);
	wire wide_scheme = scheme_in[1];
	wire [1:0] trans_level = fault_no_walk_in ? (wide_scheme ? LEVEL_0 : LEVEL_1)
		: table_level_in;
	wire [1:0] rec_level = (fault_class_in == FAULT_WALK) ? walk_level_in
		: (fault_class_in == FAULT_PERM) ? final_level_in
		: (fault_class_in == FAULT_TRANS) ? trans_level : table_level_in;
	// Atomic: write only when write alone is missing on a permission fault
	wire atomic_dir = (fault_class_in == FAULT_PERM) & atomic_no_write_in
		& ~atomic_no_read_in;
	wire rec_dir = atomic_in ? atomic_dir : write_not_read_in;
	wire rec_walkf = fault_external_in & (fault_class_in == FAULT_WALK);
	wire [31:0] syn0_capture = ({24'h00_0000, first_stage_bank_index_in} << SYN_IDX_LO)
		| ({31'h0000_0000, fault_async_in} << SYN_ASYNC_POS)
		| ({31'h0000_0000, rec_walkf} << SYN_WALKF_POS)
		| ({31'h0000_0000, nonsecure_attr_in} << SYN_NS_POS)
		| ({31'h0000_0000, instr_not_data_in} << SYN_INSTR_POS)
		| ({31'h0000_0000, priv_not_unpriv_in} << SYN_PRIV_POS)
		| ({31'h0000_0000, rec_dir} << SYN_DIR_POS)
		| ({30'h0000_0000, rec_level} << SYN_LVL_LO);
	wire [31:0] syn0_sw = merge_strb(syndrome_0, pwdata_in, pstrb_in);
	// Hardware capture wins over a software write in the same cycle
	wire [31:0] next_syndrome_0 = fault_record_in ? (syn0_capture & syn0_rmask)
		: ((wr_ok & hit_syn0) ? (syn0_sw & syn0_rmask) : syndrome_0);

	// ==========================================================
	// Plain storage registers
	wire [31:0] next_syndrome_1 = (wr_ok & hit_syn1) ? merge_strb(syndrome_1, pwdata_in,
		pstrb_in) : syndrome_1;
	wire [31:0] next_attr_0 = (wr_ok & hit_attr0) ? merge_strb(attr_0, pwdata_in, pstrb_in)
		: attr_0;
	wire [31:0] next_attr_1 = (wr_ok & hit_attr1) ? merge_strb(attr_1, pwdata_in, pstrb_in)
		: attr_1;
	wire [31:0] next_normal_remap = (wr_ok & hit_remap) ? merge_strb(normal_remap, pwdata_in,
		pstrb_in) : normal_remap;

	always_ff @(posedge core_clk_in)
	begin
		if (!rstn_in)
		begin
			syndrome_0 <= RST_SYNDROME;
			syndrome_1 <= RST_SYNDROME;
			attr_0 <= RST_ATTR;
			attr_1 <= RST_ATTR;
			normal_remap <= RST_REMAP;
		end
		else
		begin
			syndrome_0 <= next_syndrome_0;
			syndrome_1 <= next_syndrome_1;
			attr_0 <= next_attr_0;
			attr_1 <= next_attr_1;
			normal_remap <= next_normal_remap;
		end
	end

	// ==========================================================
	// Read path, sampled in the setup phase
	wire [31:0] read_mux = hit_fs ? fs_read
		: hit_syn0 ? (syndrome_0 & syn0_rmask)
		: hit_syn1 ? syndrome_1
		: hit_attr0 ? attr_0
		: hit_attr1 ? attr_1
		: hit_remap ? normal_remap : 32'h0000_0000;

	always_ff @(posedge core_clk_in)
	begin
		if (!rstn_in)
		begin
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end
		else if (setup_phase)
		begin
			prdata_out <= pwrite_in ? 32'h0000_0000 : read_mux;
			pslverr_out <= ~mapped;
		end
	end

	// ==========================================================
	// Attribute lookup
	wire short_scheme = (scheme_in == SCHEME_SHORT);
	wire [63:0] attr_all = {attr_1, attr_0};
	wire [7:0] attr_pick = attr_all[attr_index_in*ATTR_W +: ATTR_W];
	wire remap_live = short_scheme & region_normal_in;
	// Index 6 inner code is passed through raw; any special meaning is downstream
	wire [1:0] next_outer = remap_live ? pick_map(normal_remap[31:16], attr_index_in)
		: CACHE_NONE;
	wire [1:0] next_inner = remap_live ? pick_map(normal_remap[15:0], attr_index_in)
		: CACHE_NONE;

	always_ff @(posedge core_clk_in)
	begin
		if (!rstn_in)
		begin
			use_indirection_out <= 1'b0;
			attr_out <= 8'h00;
			outer_cache_map_out <= CACHE_NONE;
			inner_cache_map_out <= CACHE_NONE;
		end
		else
		begin
			use_indirection_out <= ~short_scheme;
			attr_out <= short_scheme ? 8'h00 : attr_pick;
			outer_cache_map_out <= next_outer;
			inner_cache_map_out <= next_inner;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	a_restore_keeps_stall: assert property (
		(wr_ok & hit_restore & ~fault_record_in & ~resume_wr) |=> (stall == $past(stall)))
		else $error("restore write changed stall flag");
	a_restore_sets_bits: assert property (
		(wr_ok & hit_restore & ~fault_record_in & (pstrb_in == 4'hF))
		|=> (fs_bits == ($past(pwdata_in) & FS_STORE_MASK)))
		else $error("restore write did not load fault status");
	a_stall_only_resume: assert property (
		$fell(stall) |-> $past(resume_wr))
		else $error("stall flag cleared without resume write");
	a_index_hidden: assert property (
		(setup_phase & ~pwrite_in & hit_syn0 & ~index_ok)
		|=> ((prdata_out & SYN0_IDX_MASK) == 32'h0000_0000))
		else $error("bank index visible without nested support");
	a_walk_fault_bit: assert property (
		(fault_record_in & (fault_class_in != FAULT_WALK)) |=> ~syndrome_0[SYN_WALKF_POS])
		else $error("walk fault bit set for non walk fault");
	a_level_no_walk: assert property (
		(fault_record_in & (fault_class_in == FAULT_TRANS) & fault_no_walk_in)
		|=> (syndrome_0[1:0] == ($past(wide_scheme) ? LEVEL_0 : LEVEL_1)))
		else $error("disabled walk level wrong");
	a_level_perm: assert property (
		(fault_record_in & (fault_class_in == FAULT_PERM)) |=> (syndrome_0[1:0] ==
		$past(final_level_in)))
		else $error("permission fault level wrong");
	a_atomic_read: assert property (
		(fault_record_in & atomic_in & (atomic_no_read_in | (fault_class_in != FAULT_PERM)))
		|=> ~syndrome_0[SYN_DIR_POS])
		else $error("atomic fault direction not read");
	a_reserved_zero: assert property (
		(setup_phase & ~pwrite_in & hit_syn0)
		|=> ((prdata_out & ~SYN0_MASK) == 32'h0000_0000))
		else $error("reserved syndrome bit set");
	a_remap_outer: assert property (
		(~remap_live) |=> (outer_cache_map_out == CACHE_NONE))
		else $error("outer map applied outside short normal region");

endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
	import ctx_regs_pkg::*;
	// ==========================================================
	// Signals
	logic core_clk_in = 1'h0, rstn_in = 1'h0, psel_in = 1'h0, penable_in = 1'h0;
	logic pwrite_in = 1'h0, pready_out, pslverr_out, use_indirection_out, stalled_out;
	logic [11:0] paddr_in = 12'h0;
	logic [31:0] pwdata_in = 32'h0, prdata_out, rd, ex, sn;
	logic [3:0] pstrb_in = 4'hF;
	logic [7:0] attr_out, fault_bits_in = 8'h0, first_stage_bank_index_in = 8'h0;
	logic [1:0] outer_cache_map_out, inner_cache_map_out, scheme_in = 2'h1;
	logic [1:0] walk_level_in = 2'h2, table_level_in = 2'h3, final_level_in = 2'h1;
	logic nested_support_flag_in = 1'h1, stage2_format_in = 1'h1, secure_bank_in = 1'h1;
	logic fault_record_in = 1'h0, fault_stall_in = 1'h0, fault_async_in = 1'h0;
	logic fault_external_in = 1'h0, fault_no_walk_in = 1'h0, nonsecure_attr_in = 1'h0;
	logic instr_not_data_in = 1'h0, priv_not_unpriv_in = 1'h0, write_not_read_in = 1'h1;
	logic atomic_in = 1'h0, atomic_no_read_in = 1'h0, atomic_no_write_in = 1'h0;
	logic region_normal_in = 1'h0, er;
	logic [2:0] attr_index_in = 3'h0;
	fault_class_t fault_class_in = FAULT_WALK;
	logic [39:0] f;
	int err_count = 0, check_count = 0, cyc = 0;
	localparam logic [31:0] nm = 32'h3C5A_96C3;
	localparam logic [63:0] am = 64'h8877_6655_4433_CCDD;
	typedef struct {logic [11:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e; logic r;} row_t;
	row_t rr [8] = '{
		'{12'h00C, 32'hFFFF_FFFF, 4'hF, 32'h00FF_0D73, 1'h0},
		'{12'h010, 32'hA5A5_5A5A, 4'hF, 32'hA5A5_5A5A, 1'h0},
		'{12'h014, 32'h4433_2211, 4'hF, 32'h4433_2211, 1'h0},
		'{12'h014, 32'hAABB_CCDD, 4'h3, 32'h4433_CCDD, 1'h0},
		'{12'h018, 32'h8877_6655, 4'hF, 32'h8877_6655, 1'h0},
		'{12'h01C, 32'h3C5A_96C3, 4'hF, 32'h3C5A_96C3, 1'h0},
		'{12'h008, 32'h0000_0000, 4'hF, 32'h0000_0000, 1'h0},
		'{12'h020, 32'h1234_5678, 4'hF, 32'h0000_0000, 1'h1}};
	// One nibble per field: class, ext, no walk, scheme, atomic, no rd, no wr, walkf, dir, level
	logic [39:0] fr [12] = '{
		40'h0_1_0_1_0_0_0_1_1_2, 40'h0_0_0_1_0_0_0_0_0_2, 40'h1_1_0_1_0_0_0_0_1_3,
		40'h1_0_1_2_0_0_0_0_1_0, 40'h1_0_1_0_0_0_0_0_1_1, 40'h1_0_1_3_0_0_0_0_1_0,
		40'h2_0_0_1_0_0_0_0_1_3, 40'h3_0_0_1_1_0_1_0_1_1, 40'h3_0_0_1_1_1_1_0_0_1,
		40'h3_0_0_1_1_1_0_0_0_1, 40'h1_0_0_1_1_0_1_0_0_3, 40'h3_1_0_1_0_0_0_0_1_1};

	context_fault_syndrome_attr_regs DUT (.*);

	// ==========================================================
	// Clock and watchdog
	initial forever #25 core_clk_in = ~core_clk_in;

	always @(posedge core_clk_in)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_count++;
			results();
		end
	end

	// ==========================================================
	// Tasks
	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// Idle cycle after each transfer keeps one assignment per step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		psel_in <= 1'h1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		pstrb_in <= s;
		@(posedge core_clk_in);
		penable_in <= 1'h1;
		@(posedge core_clk_in);
		while (pready_out !== 1'h1) @(posedge core_clk_in);
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'h0;
		penable_in <= 1'h0;
		@(posedge core_clk_in);
	endtask

	task rc(input logic [11:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0, 4'hF);
		chk(rd, e);
	endtask

	task rec(input logic [7:0] b, input logic st);
		fault_bits_in <= b;
		fault_stall_in <= st;
		fault_record_in <= 1'h1;
		@(posedge core_clk_in);
		fault_record_in <= 1'h0;
	endtask

	task results;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================================
	// Sequence
	initial
	begin
		repeat (8) @(posedge core_clk_in);
		rstn_in <= 1'h1;
		@(posedge core_clk_in);
		for (int i = 0; i < 8; i++)
		begin
			apb(1'h1, rr[i].a, rr[i].d, rr[i].s);
			rc(rr[i].a, rr[i].e);
			chk(32'(er), 32'(rr[i].r));
		end
		for (int i = 0; i < 12; i++)
		begin
			f = fr[i];
			fault_class_in <= fault_class_t'(f[37:36]);
			fault_external_in <= f[32];
			fault_no_walk_in <= f[28];
			scheme_in <= f[25:24];
			atomic_in <= f[20];
			atomic_no_read_in <= f[16];
			atomic_no_write_in <= f[12];
			// Atomic rows drive the opposite plain direction, so it must be overridden
			write_not_read_in <= f[4] ^ f[20];
			fault_async_in <= i[3];
			nonsecure_attr_in <= i[2];
			instr_not_data_in <= i[1];
			priv_not_unpriv_in <= i[0];
			first_stage_bank_index_in <= 8'(i * 19);
			rec(8'h0, 1'h0);
			ex = {8'h0, 8'(i * 19), 4'h0, i[3], f[8], 1'h0, i[2], 1'h0, i[1], i[0], f[4],
				2'h0, f[1:0]};
			rc(12'h00C, ex);
		end
		for (int i = 0; i < 8; i++)
		begin
			attr_index_in <= 3'(i);
			scheme_in <= 2'h1;
			region_normal_in <= (i != 3);
			repeat (2) @(posedge core_clk_in);
			chk(32'({use_indirection_out, attr_out}), {23'h1, am[8 * i +: 8]});
			scheme_in <= 2'h0;
			repeat (2) @(posedge core_clk_in);
			ex = (i == 3) ? 32'h0 : {28'h0, nm[16 + 2 * i +: 2], nm[2 * i +: 2]};
			sn = 32'({use_indirection_out, attr_out, outer_cache_map_out, inner_cache_map_out});
			chk(sn, ex);
		end
		// ==========================================================
		// Status, restore and resume
		scheme_in <= 2'h1;
		rec(8'h05, 1'h1);
		rc(12'h000, 32'h4000_020A);
		chk(32'(stalled_out), 32'h1);
		apb(1'h1, 12'h004, 32'hBFFF_F9E0, 4'hF);
		rc(12'h000, 32'hC000_03E0);
		apb(1'h1, 12'h000, 32'hFFFF_FFFF, 4'hF);
		rc(12'h000, 32'h4000_0200);
		chk(32'(stalled_out), 32'h1);
		apb(1'h1, 12'h008, 32'h0, 4'hF);
		rc(12'h000, 32'h0000_0200);
		chk(32'(stalled_out), 32'h0);
		apb(1'h1, 12'h004, 32'h0000_01FE, 4'h2);
		rc(12'h000, 32'h0000_0300);
		// Without nested or secure support those fields must stay zero
		nested_support_flag_in <= 1'h0;
		secure_bank_in <= 1'h0;
		apb(1'h1, 12'h00C, 32'hFFFF_FFFF, 4'hF);
		rc(12'h00C, 32'h0000_0C73);
		rec(8'h01, 1'h1);
		rstn_in <= 1'h0;
		repeat (8) @(posedge core_clk_in);
		rstn_in <= 1'h1;
		@(posedge core_clk_in);
		chk(32'(stalled_out), 32'h0);
		rc(12'h000, 32'h0000_0200);
		for (int a = 12'h00C; a <= 12'h01C; a += 4)
			rc(12'(a), 32'h0);
		results();
	end
endmodule
